// File: hw/fsd_top.sv
// Flash security state logic: reset-time load, decode, and gating of debug, trace and commands.
//
// Function
// - Options byte sits at 0xFF0F, also at 0xBF0F when page 0x3F selected.
// - Every reset sequence copies the whole options byte into the security register.
// - Bits 1:0 security state, bits 7:6 backdoor enable, bits 5:2 spare.
// - Backdoor access enabled only for backdoor field 10, otherwise disabled.
// - Unsecured only when security field is 10; anything else means secured.
// - Security bits live in flash, so secured state survives reset and power-down.
// - Options byte is erased and programmed by ordinary memory commands.
// - Secured, or unsecured normal single chip, allows only restricted memory commands.
// - Secured normal mode refuses debug; secured special mode limits it to registers.
// - When secured, debug port cannot reach internal flash or EEPROM.
// - When secured, code execution tracing by the comparator module is disabled.
// - A newly programmed unsecured field takes effect only after the next reset.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fsd_params.svh"

module fsd_top
   import fsd_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Operating mode, caught after reset release
   input  wire logic        special_mode_in,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Flash array read port for the reset-time copy
   output logic             flash_rd_req,
   output logic [15:0]      flash_rd_addr,
   input  wire logic [7:0]  flash_rd_data,
   input  wire logic        flash_rd_valid,
   // CPU address watch for the options byte
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_page,
   output logic             opt_byte_hit,
   // Background debug port access check
   input  wire logic        dbg_req,
   input  wire logic        dbg_firmware,
   input  wire logic [15:0] dbg_addr,
   output logic             dbg_grant,
   output logic             dbg_deny,
   // Memory command issue to the flash controller
   output logic             cmd_valid,
   output logic [7:0]       cmd_code,
   // Security state outputs
   output logic             secured,
   output logic             backdoor_enable,
   output logic             trace_enable
);

   // ----------------------------------------------------------------
   // State registers and decode
   // ----------------------------------------------------------------

   fsd_state_type r;
   fsd_state_type next_r;
   fsd_sec_type   sec;

   // Decode of the security register contents.
   fsd_sec_decode fsd_sec_decode_inst (
      .opt_byte (r.sec_byte),
      .loaded   (r.loaded),
      .sec      (sec)
   );

   // Helper terms for the bus and the gating logic.
   logic       setup;
   logic       wr_access;
   logic       mapped;
   logic       cmd_write;
   logic       cmd_ok;
   logic       clear_refused;
   logic       restricted;
   logic       dbg_ok;
   logic [7:0] wr_code;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------

   // Setup phase starts an access; writes take effect in the access phase.
   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pready && pwrite;
   assign mapped    = (paddr == `FSD_OFS_OPTION) || (paddr == `FSD_OFS_STATUS) ||
                      (paddr == `FSD_OFS_CONTROL) || (paddr == `FSD_OFS_COMMAND);
   assign cmd_write = wr_access && (paddr == `FSD_OFS_COMMAND);
   assign wr_code   = pwdata[7:0];
   assign clear_refused = wr_access && (paddr == `FSD_OFS_STATUS) &&
                          pwdata[`FSD_ST_REFUSED];

   // ----------------------------------------------------------------
   // Gating from the single secured signal
   // ----------------------------------------------------------------

   // Restricted command set when secured in any mode or in normal single chip.
   assign restricted = r.secured || !r.special_mode;
   // Option byte commands are treated like any other location.
   assign cmd_ok     = !restricted || fsd_cmd_restricted_ok(wr_code);

   // Debug access: free when unsecured, none in secured normal mode,
   // hardware commands below the register space top in secured special mode.
   always_comb begin
      if (!r.secured) begin
         dbg_ok = 1'b1;
      end else if (!r.special_mode) begin
         dbg_ok = 1'b0;
      end else begin
         dbg_ok = !dbg_firmware && (dbg_addr < `FSD_REG_SPACE_TOP);
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Computes the next copy of all state.
   always_comb begin
      next_r = r;
      next_r.cmd_valid = 1'b0;
      next_r.dbg_grant = 1'b0;
      next_r.dbg_deny  = 1'b0;

      // Reset-time load of the options byte; the register is never written afterwards.
      unique case (r.st)
         FSD_LOAD_REQ: begin
            next_r.special_mode  = special_mode_in;
            next_r.flash_rd_req  = 1'b1;
            next_r.flash_rd_addr = `FSD_OPT_ADDR;
            next_r.st            = FSD_LOAD_WAIT;
         end
         FSD_LOAD_WAIT: begin
            if (flash_rd_valid) begin
               next_r.sec_byte     = flash_rd_data;
               next_r.loaded       = 1'b1;
               next_r.flash_rd_req = 1'b0;
               next_r.st           = FSD_RUN;
            end
         end
         FSD_RUN: begin
            next_r.flash_rd_req = 1'b0;
         end
      endcase

      // Registered security outputs follow the decoded register.
      next_r.secured      = sec.secured;
      next_r.backdoor_en  = sec.backdoor_en;
      next_r.trace_enable = r.trace_req && !r.secured;

      // CPU accesses to the options byte, direct or through the page window.
      next_r.opt_hit = fsd_opt_hit(cpu_addr, cpu_page);

      // Debug port check answers one cycle after each request.
      if (dbg_req) begin
         next_r.dbg_grant = dbg_ok;
         next_r.dbg_deny  = !dbg_ok;
      end

      // APB answer: ready in the access cycle that follows each setup.
      next_r.pready = setup;
      if (setup) begin
         next_r.pslverr = !mapped;
         next_r.prdata  = 32'h0;
         if (!pwrite) begin
            unique case (1'b1)
               (paddr == `FSD_OFS_OPTION): begin
                  next_r.prdata[7:0] = r.sec_byte;
               end
               (paddr == `FSD_OFS_STATUS): begin
                  next_r.prdata[`FSD_ST_SECURED]  = r.secured;
                  next_r.prdata[`FSD_ST_BACKDOOR] = r.backdoor_en;
                  next_r.prdata[`FSD_ST_LOADED]   = r.loaded;
                  next_r.prdata[`FSD_ST_SPECIAL]  = r.special_mode;
                  next_r.prdata[`FSD_ST_REFUSED]  = r.refused;
               end
               (paddr == `FSD_OFS_CONTROL): begin
                  next_r.prdata[0] = r.trace_req;
               end
               (paddr == `FSD_OFS_COMMAND): begin
                  next_r.prdata[7:0] = r.cmd_code;
               end
               default: begin
                  next_r.prdata = 32'h0;
               end
            endcase
         end
      end else begin
         next_r.pslverr = 1'b0;
      end

      // Control register write.
      if (wr_access && (paddr == `FSD_OFS_CONTROL)) begin
         next_r.trace_req = pwdata[0];
      end

      // Refused flag: write one clears, a new refusal in the same cycle wins.
      if (clear_refused) begin
         next_r.refused = 1'b0;
      end

      // Command issue through the gate; refused codes still load cmd_code but never raise cmd_valid.
      if (cmd_write) begin
         next_r.cmd_code = wr_code;
         if (cmd_ok && r.loaded) begin
            next_r.cmd_valid = 1'b1;
         end else begin
            next_r.refused = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Synchronous reset starts a fresh load and holds the part secured.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r.st            <= FSD_LOAD_REQ;
         r.sec_byte      <= `FSD_RST_SEC_BYTE;
         r.loaded        <= 1'b0;
         r.special_mode  <= 1'b0;
         r.flash_rd_req  <= 1'b0;
         r.flash_rd_addr <= 16'h0000;
         r.pready        <= 1'b0;
         r.pslverr       <= 1'b0;
         r.prdata        <= 32'h0000_0000;
         r.trace_req     <= `FSD_RST_CONTROL;
         r.trace_enable  <= 1'b0;
         r.refused       <= 1'b0;
         r.cmd_code      <= 8'h00;
         r.cmd_valid     <= 1'b0;
         r.dbg_grant     <= 1'b0;
         r.dbg_deny      <= 1'b0;
         r.opt_hit       <= 1'b0;
         r.secured       <= 1'b1;
         r.backdoor_en   <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from a flip-flop
   // ----------------------------------------------------------------

   // Bus outputs.
   assign pready  = r.pready;
   assign pslverr = r.pslverr;
   assign prdata  = r.prdata;

   // Flash read port.
   assign flash_rd_req  = r.flash_rd_req;
   assign flash_rd_addr = r.flash_rd_addr;

   // Watches and gates.
   assign opt_byte_hit    = r.opt_hit;
   assign dbg_grant       = r.dbg_grant;
   assign dbg_deny        = r.dbg_deny;
   assign cmd_valid       = r.cmd_valid;
   assign cmd_code        = r.cmd_code;
   assign secured         = r.secured;
   assign backdoor_enable = r.backdoor_en;
   assign trace_enable    = r.trace_enable;

endmodule

`default_nettype wire

// File: shared/fsd_params.svh
// Constants for the flash security state decode block.
`ifndef FSD_PARAMS_SVH
`define FSD_PARAMS_SVH

// ----------------------------------------------------------------
// Options and security byte location
// ----------------------------------------------------------------
`define FSD_OPT_ADDR        16'hFF0F
`define FSD_OPT_WIN_ADDR    16'hBF0F
`define FSD_OPT_PAGE        8'h3F

// ----------------------------------------------------------------
// Field positions inside the options byte
// ----------------------------------------------------------------
`define FSD_SEC_LSB         0
`define FSD_SEC_MSB         1
`define FSD_SPARE_LSB       2
`define FSD_SPARE_MSB       5
`define FSD_KEY_LSB         6
`define FSD_KEY_MSB         7

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define FSD_SEC_UNSECURED   2'h2
`define FSD_SEC_RECOMMENDED 2'h1
`define FSD_KEY_ENABLED     2'h2

// ----------------------------------------------------------------
// Register offsets on the APB port
// ----------------------------------------------------------------
`define FSD_OFS_OPTION      12'h000
`define FSD_OFS_STATUS      12'h004
`define FSD_OFS_CONTROL     12'h008
`define FSD_OFS_COMMAND     12'h00C

// ----------------------------------------------------------------
// Reset values and status bit positions
// ----------------------------------------------------------------
`define FSD_RST_SEC_BYTE    8'hFF
`define FSD_RST_CONTROL     1'h0
`define FSD_ST_SECURED      0
`define FSD_ST_BACKDOOR     1
`define FSD_ST_LOADED       2
`define FSD_ST_SPECIAL      3
`define FSD_ST_REFUSED      8

// ----------------------------------------------------------------
// Memory command codes kept in the restricted set
// ----------------------------------------------------------------
`define FSD_CMD_ERASE_VERIFY 8'h01
`define FSD_CMD_MASS_ERASE   8'h08
`define FSD_CMD_KEY_ACCESS   8'h0C

// ----------------------------------------------------------------
// Top of the peripheral register space for the debug port
// ----------------------------------------------------------------
`define FSD_REG_SPACE_TOP   16'h0400

`endif

// File: shared/fsd_pkg.sv
// Types and shared decode functions of the flash security state decode block.
`include "fsd_params.svh"

package fsd_pkg;

   // ----------------------------------------------------------------
   // Load sequence states, Gray coded along the path
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FSD_LOAD_REQ  = 2'h0,
      FSD_LOAD_WAIT = 2'h1,
      FSD_RUN       = 2'h3
   } fsd_load_state_type;

   // ----------------------------------------------------------------
   // Decoded security state carried as one group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic secured;
      logic backdoor_en;
   } fsd_sec_type;

   // ----------------------------------------------------------------
   // Whole state of the top module
   // ----------------------------------------------------------------
   typedef struct packed {
      fsd_load_state_type st;
      logic [7:0]         sec_byte;
      logic               loaded;
      logic               special_mode;
      logic               flash_rd_req;
      logic [15:0]        flash_rd_addr;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
      logic               trace_req;
      logic               trace_enable;
      logic               refused;
      logic [7:0]         cmd_code;
      logic               cmd_valid;
      logic               dbg_grant;
      logic               dbg_deny;
      logic               opt_hit;
      logic               secured;
      logic               backdoor_en;
   } fsd_state_type;

   // True when a CPU address reaches the options byte directly or through the page window.
   function automatic logic fsd_opt_hit(input logic [15:0] addr, input logic [7:0] page);
      fsd_opt_hit = (addr == `FSD_OPT_ADDR) ||
                    ((addr == `FSD_OPT_WIN_ADDR) && (page == `FSD_OPT_PAGE));
   endfunction

   // True when a memory command belongs to the restricted set.
   function automatic logic fsd_cmd_restricted_ok(input logic [7:0] code);
      fsd_cmd_restricted_ok = (code == `FSD_CMD_ERASE_VERIFY) ||
                              (code == `FSD_CMD_MASS_ERASE) ||
                              (code == `FSD_CMD_KEY_ACCESS);
   endfunction

endpackage

// File: hw/fsd_sec_decode.sv
// Decoder from the loaded options byte to secured state and backdoor enable.
`timescale 1ns/1ns
`default_nettype none
`include "fsd_params.svh"

module fsd_sec_decode
   import fsd_pkg::*;
(
   // Loaded options byte and load status
   input  wire logic [7:0] opt_byte,
   input  wire logic       loaded,
   // Decoded state
   output var fsd_sec_type sec
);

   // Until the byte is loaded the part stays secured with no backdoor.
   always_comb begin
      sec.secured     = !loaded ||
                        (opt_byte[`FSD_SEC_MSB:`FSD_SEC_LSB] != `FSD_SEC_UNSECURED);
      sec.backdoor_en = loaded &&
                        (opt_byte[`FSD_KEY_MSB:`FSD_KEY_LSB] == `FSD_KEY_ENABLED);
   end

endmodule

`default_nettype wire

// File: tb/fsd_top_sva.sv
// Checker of the security decode and access gating at the top ports.
`timescale 1ns/1ns
`default_nettype none

module fsd_chk (
   // Clock, reset and mode
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        special_mode_in,
   // Load port
   input wire logic        flash_rd_req,
   input wire logic [15:0] flash_rd_addr,
   input wire logic [7:0]  flash_rd_data,
   input wire logic        flash_rd_valid,
   // Address watch
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0]  cpu_page,
   input wire logic        opt_byte_hit,
   // Debug check
   input wire logic        dbg_req,
   input wire logic        dbg_firmware,
   input wire logic [15:0] dbg_addr,
   input wire logic        dbg_grant,
   input wire logic        dbg_deny,
   // Commands and state
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_code,
   input wire logic        secured,
   input wire logic        backdoor_enable,
   input wire logic        trace_enable
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // Address match follows the watched address one cycle later.
   hit_decode_a: assert property (!$past(sys_rst) |-> opt_byte_hit == (($past(cpu_addr) == 16'hFF0F)
      || ($past(cpu_addr) == 16'hBF0F && $past(cpu_page) == 8'h3F))) else $error("address match wrong");
   load_addr_a: assert property (flash_rd_req |-> flash_rd_addr == 16'hFF0F)
      else $error("load address wrong");
   // Decoded state appears two edges after the captured byte.
   sec_decode_a: assert property (flash_rd_req && flash_rd_valid |=> ##1
      (secured == ($past(flash_rd_data[1:0], 2) != 2'h2)) &&
      (backdoor_enable == ($past(flash_rd_data[7:6], 2) == 2'h2))) else $error("decode wrong");
   sec_hold_a: assert property (!$past(flash_rd_req) && !$past(flash_rd_req, 2) &&
      !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(secured)) else $error("secured changed");
   dbg_answer_a: assert property (dbg_req |=> dbg_grant != dbg_deny)
      else $error("debug answer missing");
   dbg_normal_a: assert property (dbg_req && secured && !special_mode_in |=> dbg_deny)
      else $error("secured normal debug granted");
   dbg_special_a: assert property (dbg_req && secured && special_mode_in |=>
      dbg_grant == (!$past(dbg_firmware) && $past(dbg_addr) < 16'h0400)) else $error("special debug wrong");
   dbg_open_a: assert property (dbg_req && !secured |=> dbg_grant)
      else $error("unsecured debug denied");
   trace_gate_a: assert property (secured |-> !trace_enable)
      else $error("trace while secured");
   cmd_restrict_a: assert property (cmd_valid && (secured || !special_mode_in) |->
      cmd_code inside {8'h01, 8'h08, 8'h0C}) else $error("restricted command passed");

   cover property (dbg_grant && secured);
   cover property (cmd_valid && !secured);
   cover property (!secured && backdoor_enable);
endmodule

bind fsd_top fsd_chk fsd_chk_inst (.core_clk, .sys_rst, .special_mode_in, .flash_rd_req,
   .flash_rd_addr, .flash_rd_data, .flash_rd_valid, .cpu_addr, .cpu_page, .opt_byte_hit,
   .dbg_req, .dbg_firmware, .dbg_addr, .dbg_grant, .dbg_deny, .cmd_valid, .cmd_code,
   .secured, .backdoor_enable, .trace_enable);

`default_nettype wire

// File: tb/fsd_top_bench.sv
// Self-checking bench of the flash security state decode top.
`timescale 1ns/1ns
`default_nettype none

module fsd_top_bench;
   import fsd_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, special_mode_in = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic flash_rd_req, flash_rd_valid = 1'b0, opt_byte_hit, rerr;
   logic [15:0] flash_rd_addr, cpu_addr = 16'h0000, dbg_addr = 16'h0000;
   logic [7:0] flash_rd_data = 8'h00, cpu_page = 8'h00, cmd_code;
   logic dbg_req = 1'b0, dbg_firmware = 1'b0, dbg_grant, dbg_deny, cmd_valid;
   logic secured, backdoor_enable, trace_enable;
   int err_count = 0, num_checks = 0, cycles = 0;

   fsd_top fsd_top_inst (.core_clk, .sys_rst, .special_mode_in, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .pslverr, .prdata, .flash_rd_req, .flash_rd_addr,
      .flash_rd_data, .flash_rd_valid, .cpu_addr, .cpu_page, .opt_byte_hit, .dbg_req,
      .dbg_firmware, .dbg_addr, .dbg_grant, .dbg_deny, .cmd_valid, .cmd_code, .secured,
      .backdoor_enable, .trace_enable);

   // Clock at 125 MHz.
   initial begin
      forever #4 core_clk = ~core_clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         close_out();
      end
   end

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   // One APB transfer; waits for pready before release.
   task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Resets the block and answers its load request with the given byte.
   task automatic boot(input logic [7:0] b, input logic sp);
      sys_rst <= 1'b1;
      special_mode_in <= sp;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      while (flash_rd_req !== 1'b1) begin
         @(posedge core_clk);
      end
      repeat (2) @(posedge core_clk);
      check(flash_rd_addr === 16'hFF0F, "load address");
      flash_rd_data <= b;
      flash_rd_valid <= 1'b1;
      @(posedge core_clk);
      flash_rd_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   // Sends one debug request and judges the answer one cycle later.
   task automatic probe(input logic fw, input logic [15:0] a, input logic g);
      @(posedge core_clk);
      dbg_req <= 1'b1;
      dbg_firmware <= fw;
      dbg_addr <= a;
      @(posedge core_clk);
      dbg_req <= 1'b0;
      @(posedge core_clk);
      check(dbg_grant === g && dbg_deny === !g, "debug answer");
   endtask

   // Issues one memory command, judges issue or refusal, then clears the flag.
   task automatic cmd(input logic [7:0] c, input logic ok);
      apb(1'b1, 12'h00C, {24'h0, c});
      @(posedge core_clk);
      check(cmd_valid === ok && (!ok || cmd_code === c), "command issue");
      apb(1'b0, 12'h004, 32'h0);
      check(rdat[8] === !ok, "refusal flag");
      apb(1'b1, 12'h004, 32'h100);
   endtask

   // Requests tracing and judges the gated enable.
   task automatic trace(input logic exp);
      apb(1'b1, 12'h008, 32'h1);
      repeat (3) @(posedge core_clk);
      check(trace_enable === exp, "trace enable");
   endtask

   // Every pair of field codes, with a stale load pulse and an option write afterwards.
   task automatic t_decode();
      logic [7:0] b;
      for (int i = 0; i < 16; i++) begin
         b = {i[3:2], 4'h5 ^ i[3:0], i[1:0]};
         boot(b, i[0]);
         check(secured === (b[1:0] != 2'h2), "secured state");
         check(backdoor_enable === (b[7:6] == 2'h2), "backdoor enable");
         apb(1'b1, 12'h000, {24'h0, ~b});
         flash_rd_data <= ~b;
         flash_rd_valid <= 1'b1;
         @(posedge core_clk);
         flash_rd_valid <= 1'b0;
         apb(1'b0, 12'h000, 32'h0);
         check(rdat === {24'h0, b}, "option copy");
         apb(1'b0, 12'h004, 32'h0);
         check(rdat[3:0] === {i[0], 1'b1, b[7:6] == 2'h2, b[1:0] != 2'h2}, "status");
      end
   endtask

   task automatic t_secure_normal();
      boot(8'h00, 1'b0);
      probe(1'b0, 16'h0100, 1'b0);
      probe(1'b1, 16'h0010, 1'b0);
      cmd(8'h08, 1'b1);
      cmd(8'h02, 1'b0);
      cmd(8'h0C, 1'b1);
      cmd(8'h01, 1'b1);
      trace(1'b0);
   endtask

   task automatic t_secure_special();
      boot(8'h03, 1'b1);
      probe(1'b0, 16'h03FF, 1'b1);
      probe(1'b0, 16'h0400, 1'b0);
      probe(1'b1, 16'h0010, 1'b0);
      cmd(8'h02, 1'b0);
      trace(1'b0);
   endtask

   task automatic t_unsecure();
      boot(8'h02, 1'b0);
      probe(1'b1, 16'h8000, 1'b1);
      cmd(8'h02, 1'b0);
      cmd(8'h01, 1'b1);
      boot(8'h02, 1'b1);
      cmd(8'h02, 1'b1);
      trace(1'b1);
   endtask

   // Direct and windowed addresses of the option byte, with near misses.
   task automatic t_hit();
      logic [15:0] ha [4];
      logic [7:0] hp [4];
      ha = '{16'hFF0F, 16'hBF0F, 16'hBF0F, 16'hFF0E};
      hp = '{8'h00, 8'h3F, 8'h3E, 8'h3F};
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         cpu_addr <= ha[k];
         cpu_page <= hp[k];
         repeat (2) @(posedge core_clk);
         check(opt_byte_hit === (k < 2), "option byte match");
      end
      apb(1'b0, 12'h010, 32'h0);
      check(rerr === 1'b1 && rdat === 32'h0, "unmapped read");
   endtask

   // Main sequence.
   initial begin
      t_decode();
      t_secure_normal();
      t_secure_special();
      t_unsecure();
      t_hit();
      close_out();
   end
endmodule

`default_nettype wire
